// ==== hdl/cmf_pkg.sv ====
package cmf_pkg;

	// Sizes and register port layout.
	localparam int CMF_MAX_FIFOS = 32;
	localparam int CMF_SLOT_W = 5;
	localparam int CMF_ADDR_W = 7;
	localparam logic [1:0] CMF_SEL_CTRL = 2'h0;
	localparam logic [1:0] CMF_SEL_INT = 2'h1;
	localparam logic [1:0] CMF_SEL_UPTR = 2'h2;
	localparam logic [2:0] CMF_MODE_CONFIG = 3'h4;

	// Control register field positions.
	localparam int CMF_B_SIZE_LO = 16;
	localparam int CMF_B_RESET = 14;
	localparam int CMF_B_ADVANCE = 13;
	localparam int CMF_B_PAYLOAD = 12;
	localparam int CMF_B_DIR = 7;
	localparam int CMF_B_ABORTED = 6;
	localparam int CMF_B_ARB_LOST = 5;
	localparam int CMF_B_SEND_ERR = 4;
	localparam int CMF_B_SEND_REQ = 3;
	localparam int CMF_B_RTR_EN = 2;
	localparam int CMF_B_PRIO_LO = 0;

	// Interrupt status register field positions.
	localparam int CMF_B_TX_HALF = 9;
	localparam int CMF_B_TX_EMPTY = 8;
	localparam int CMF_B_RX_OVFL = 3;
	localparam int CMF_B_RX_FULL = 2;
	localparam int CMF_B_RX_HALF = 1;
	localparam int CMF_B_RX_NEMPTY = 0;

	// Values after reset.
	localparam logic [4:0] CMF_DEPTH_RST = 5'h00;
	localparam logic [1:0] CMF_PRIO_RST = 2'h0;
	localparam logic [5:0] CMF_COUNT_RST = 6'h00;
	localparam logic [31:0] CMF_WORD_ZERO = 32'h0000_0000;

	// One event from the protocol engine, aimed at one FIFO.
	typedef struct packed {
		logic rx_store;
		logic tx_done;
		logic tx_abort;
		logic tx_arb_lost;
		logic tx_error;
		logic remote_req;
		logic [4:0] fifo;
	} cmf_eng_ev_t;

endpackage : cmf_pkg

// ==== hdl/cmf_level.sv ====
`timescale 1ns/10ps
module cmf_level (
	// Occupancy and configured depth.
	input wire logic [5:0] count,
	input wire logic [4:0] depth_code,
	// Level results.
	output logic empty,
	output logic full,
	output logic at_most_half,
	output logic at_least_half
);
	import cmf_pkg::*;

	logic [6:0] cap;
	logic [6:0] twice;

	always_comb begin
		cap = {2'h0, depth_code} + 7'h01;
		twice = {count, 1'b0};
		empty = (count == CMF_COUNT_RST);
		full = ({1'b0, count} == cap);
		at_most_half = (twice <= cap);
		at_least_half = (twice >= cap);
	end

endmodule : cmf_level

// ==== hdl/cmf_tx_pick.sv ====
`timescale 1ns/10ps
module cmf_tx_pick #(
	parameter int NUM_FIFOS = 32
) (
	// Candidates.
	input wire logic [NUM_FIFOS-1:0] ready,
	input wire logic [2*NUM_FIFOS-1:0] prio_flat,
	// Winner.
	output logic found,
	output logic [4:0] winner
);
	import cmf_pkg::*;

	logic [1:0] best;

	// Highest priority value wins; among equals the lowest index wins.
	always_comb begin
		found = 1'b0;
		winner = 5'h00;
		best = CMF_PRIO_RST;
		for (int i = 0; i < NUM_FIFOS; i++) begin
			if (ready[i] && (!found || prio_flat[2*i +: 2] > best)) begin
				found = 1'b1;
				best = prio_flat[2*i +: 2];
				winner = 5'(i);
			end
		end
	end

endmodule : cmf_tx_pick

// ==== hdl/cmf_ctrl.sv ====
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
// Overview of operation
// - Depth is the 5-bit size code plus one, from one to thirty-two messages.
// - Writing one to reset flushes the FIFO, then hardware clears the bit; zero does nothing.
// - Transmit FIFO: writing the advance bit moves the head one slot.
// - Receive FIFO: writing the advance bit moves the tail one slot, freeing it.
// - Receive FIFO stores payload only when the option is set, else full message.
// - Transmit FIFO keeps the payload-only option stored and readable but gives it no effect.
// - Direction bit one means transmit, zero means receive; flags follow it.
// - Size code and payload option are writable only in configuration mode 100.
// - Send-aborted updates on completion, on abort, and on FIFO reset.
// - Arbitration-lost and send-error clear on control read and FIFO reset.
// - Transmit half-empty flag is one while occupancy is half capacity or less.
// - Transmit empty flag is one when nothing is queued.
// - Receive overflow flag sets when an incoming message finds no free slot.
// - Receive full flag is one while every slot is occupied.
// - Receive half-full flag is one while occupancy is at least half capacity.
// - Receive not-empty flag is one while at least one message is stored.
// - Flags of the opposite direction always read zero.
// - Level flags are read-only, ignore writes, and track occupancy continuously.
// - Unimplemented control bits read zero and ignore writes.
// - User pointer reads head for transmit, tail for receive.
module cmf_ctrl #(
	parameter int NUM_FIFOS = 32
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Register port.
	input wire logic [cmf_pkg::CMF_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Module operating mode.
	input wire logic [2:0] operating_mode_field,
	// Protocol engine.
	input wire cmf_pkg::cmf_eng_ev_t eng_ev,
	output logic tx_go,
	output logic [4:0] tx_fifo,
	output logic [31:0] payload_only_map
);
	import cmf_pkg::*;

	if (NUM_FIFOS < 1 || NUM_FIFOS > CMF_MAX_FIFOS) begin : g_bad_num
		$error("cmf_ctrl: NUM_FIFOS must lie between 1 and 32");
	end

	// Per-FIFO configuration.
	logic [4:0] depth_code [NUM_FIFOS];
	logic [NUM_FIFOS-1:0] queue_reset_request;
	logic [NUM_FIFOS-1:0] payload_only_store;
	logic [NUM_FIFOS-1:0] direction_select;
	logic [NUM_FIFOS-1:0] auto_remote_reply_enable;
	logic [1:0] send_priority [NUM_FIFOS];
	logic [NUM_FIFOS-1:0] send_request;

	// Per-FIFO status.
	logic [NUM_FIFOS-1:0] send_aborted;
	logic [NUM_FIFOS-1:0] arbitration_lost;
	logic [NUM_FIFOS-1:0] send_error;
	logic [NUM_FIFOS-1:0] rx_overflow_flag;

	// Per-FIFO pointers and occupancy.
	logic [4:0] queue_user_pointer [NUM_FIFOS];
	logic [4:0] engine_pointer [NUM_FIFOS];
	logic [5:0] count [NUM_FIFOS];

	// Level results and per-cycle strobes.
	logic [NUM_FIFOS-1:0] lvl_empty;
	logic [NUM_FIFOS-1:0] lvl_full;
	logic [NUM_FIFOS-1:0] lvl_le_half;
	logic [NUM_FIFOS-1:0] lvl_ge_half;
	logic [NUM_FIFOS-1:0] wr_ctrl;
	logic [NUM_FIFOS-1:0] wr_int;
	logic [NUM_FIFOS-1:0] rd_ctrl;
	logic [NUM_FIFOS-1:0] flush;
	logic [NUM_FIFOS-1:0] advance;
	logic [NUM_FIFOS-1:0] rx_in;
	logic [NUM_FIFOS-1:0] tx_end;
	logic [NUM_FIFOS-1:0] cnt_inc;
	logic [NUM_FIFOS-1:0] cnt_dec;
	logic [NUM_FIFOS-1:0] pick_ready;
	logic [2*NUM_FIFOS-1:0] prio_flat;
	logic [31:0] rd_word;
	logic pick_found;
	logic [4:0] pick_winner;
	logic [4:0] acc_idx;
	logic [1:0] acc_sel;
	logic cfg_mode;

	// Wraps a slot index at the configured depth.
	function automatic logic [4:0] next_slot(input logic [4:0] slot, input logic [4:0] depth);
		next_slot = (slot == depth) ? 5'h00 : slot + 5'h01;
	endfunction : next_slot

	assign acc_idx = reg_addr[CMF_ADDR_W-1:2];
	assign acc_sel = reg_addr[1:0];
	assign cfg_mode = (operating_mode_field == CMF_MODE_CONFIG);

	for (genvar g = 0; g < NUM_FIFOS; g++) begin : g_level
		cmf_level u_level (
			.count(count[g]),
			.depth_code(depth_code[g]),
			.empty(lvl_empty[g]),
			.full(lvl_full[g]),
			.at_most_half(lvl_le_half[g]),
			.at_least_half(lvl_ge_half[g])
		);
	end

	// Strobes for each FIFO.
	always_comb begin
		for (int i = 0; i < NUM_FIFOS; i++) begin
			wr_ctrl[i] = reg_wr && (acc_sel == CMF_SEL_CTRL) && (acc_idx == 5'(i));
			wr_int[i] = reg_wr && (acc_sel == CMF_SEL_INT) && (acc_idx == 5'(i));
			rd_ctrl[i] = reg_rd && (acc_sel == CMF_SEL_CTRL) && (acc_idx == 5'(i));
			flush[i] = queue_reset_request[i];
			advance[i] = wr_ctrl[i] && reg_wdata[CMF_B_ADVANCE] && !flush[i];
			rx_in[i] = eng_ev.rx_store && (eng_ev.fifo == 5'(i)) && !direction_select[i]
				&& !flush[i];
			tx_end[i] = (eng_ev.tx_done || eng_ev.tx_abort) && (eng_ev.fifo == 5'(i))
				&& direction_select[i] && !flush[i];
			if (direction_select[i]) begin
				cnt_inc[i] = advance[i] && !lvl_full[i];
				cnt_dec[i] = tx_end[i] && eng_ev.tx_done && !lvl_empty[i];
			end else begin
				cnt_inc[i] = rx_in[i] && !lvl_full[i];
				cnt_dec[i] = advance[i] && !lvl_empty[i];
			end
			pick_ready[i] = direction_select[i] && send_request[i] && !lvl_empty[i]
				&& !flush[i];
			prio_flat[2*i +: 2] = send_priority[i];
		end
	end

	// Configuration fields; size and payload option only in configuration mode.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_FIFOS; i++) begin
				depth_code[i] <= CMF_DEPTH_RST;
				send_priority[i] <= CMF_PRIO_RST;
			end
			queue_reset_request <= '0;
			payload_only_store <= '0;
			direction_select <= '0;
			auto_remote_reply_enable <= '0;
		end else begin
			for (int i = 0; i < NUM_FIFOS; i++) begin
				if (wr_ctrl[i]) begin
					if (cfg_mode) begin
						depth_code[i] <= reg_wdata[CMF_B_SIZE_LO +: 5];
						payload_only_store[i] <= reg_wdata[CMF_B_PAYLOAD];
					end
					direction_select[i] <= reg_wdata[CMF_B_DIR];
					auto_remote_reply_enable[i] <= reg_wdata[CMF_B_RTR_EN];
					send_priority[i] <= reg_wdata[CMF_B_PRIO_LO +: 2];
				end
				// The flush takes one cycle, then the bit drops by itself.
				if (flush[i]) begin
					queue_reset_request[i] <= 1'b0;
				end else if (wr_ctrl[i] && reg_wdata[CMF_B_RESET]) begin
					queue_reset_request[i] <= 1'b1;
				end
			end
		end
	end

	// Send request: set by software or by a matching remote frame, cleared once empty.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			send_request <= '0;
		end else begin
			for (int i = 0; i < NUM_FIFOS; i++) begin
				if (flush[i] || !direction_select[i]) begin
					send_request[i] <= 1'b0;
				end else if (eng_ev.remote_req && (eng_ev.fifo == 5'(i))
					&& auto_remote_reply_enable[i]) begin
					send_request[i] <= 1'b1;
				end else if (wr_ctrl[i]) begin
					send_request[i] <= reg_wdata[CMF_B_SEND_REQ];
				end else if (cnt_dec[i] && !cnt_inc[i] && count[i] == 6'h01) begin
					send_request[i] <= 1'b0;
				end
			end
		end
	end

	// Transmit outcome and receive overflow flags; an event beats a clearing read or interrupt-register write.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			send_aborted <= '0;
			arbitration_lost <= '0;
			send_error <= '0;
			rx_overflow_flag <= '0;
		end else begin
			for (int i = 0; i < NUM_FIFOS; i++) begin
				if (flush[i]) begin
					send_aborted[i] <= 1'b0;
					arbitration_lost[i] <= 1'b0;
					send_error[i] <= 1'b0;
					rx_overflow_flag[i] <= 1'b0;
				end else begin
					if (tx_end[i]) begin
						send_aborted[i] <= eng_ev.tx_abort;
					end
					if (tx_end[i] && eng_ev.tx_arb_lost) begin
						arbitration_lost[i] <= 1'b1;
					end else if (rd_ctrl[i]) begin
						arbitration_lost[i] <= 1'b0;
					end
					if (tx_end[i] && eng_ev.tx_error) begin
						send_error[i] <= 1'b1;
					end else if (rd_ctrl[i]) begin
						send_error[i] <= 1'b0;
					end
					if (rx_in[i] && lvl_full[i]) begin
						rx_overflow_flag[i] <= 1'b1;
					end else if (wr_int[i] && !reg_wdata[CMF_B_RX_OVFL]) begin
						rx_overflow_flag[i] <= 1'b0;
					end
				end
			end
		end
	end

	// Pointers and occupancy.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < NUM_FIFOS; i++) begin
				queue_user_pointer[i] <= 5'h00;
				engine_pointer[i] <= 5'h00;
				count[i] <= CMF_COUNT_RST;
			end
		end else begin
			for (int i = 0; i < NUM_FIFOS; i++) begin
				if (flush[i]) begin
					queue_user_pointer[i] <= 5'h00;
					engine_pointer[i] <= 5'h00;
					count[i] <= CMF_COUNT_RST;
				end else begin
					if (direction_select[i] ? cnt_inc[i] : cnt_dec[i]) begin
						queue_user_pointer[i] <= next_slot(queue_user_pointer[i],
							depth_code[i]);
					end
					if (direction_select[i] ? cnt_dec[i] : cnt_inc[i]) begin
						engine_pointer[i] <= next_slot(engine_pointer[i], depth_code[i]);
					end
					if (cnt_inc[i] && !cnt_dec[i]) begin
						count[i] <= count[i] + 6'h01;
					end else if (cnt_dec[i] && !cnt_inc[i]) begin
						count[i] <= count[i] - 6'h01;
					end
				end
			end
		end
	end

	// Read word assembly; unimplemented and opposite-direction bits stay zero.
	always_comb begin
		rd_word = CMF_WORD_ZERO;
		for (int i = 0; i < NUM_FIFOS; i++) begin
			if (acc_idx == 5'(i)) begin
				unique case (acc_sel)
					CMF_SEL_CTRL: begin
						rd_word[CMF_B_SIZE_LO +: 5] = depth_code[i];
						rd_word[CMF_B_RESET] = queue_reset_request[i];
						rd_word[CMF_B_PAYLOAD] = payload_only_store[i];
						rd_word[CMF_B_DIR] = direction_select[i];
						rd_word[CMF_B_ABORTED] = send_aborted[i];
						rd_word[CMF_B_ARB_LOST] = arbitration_lost[i];
						rd_word[CMF_B_SEND_ERR] = send_error[i];
						rd_word[CMF_B_SEND_REQ] = send_request[i];
						rd_word[CMF_B_RTR_EN] = auto_remote_reply_enable[i];
						rd_word[CMF_B_PRIO_LO +: 2] = send_priority[i];
					end
					CMF_SEL_INT: begin
						if (direction_select[i]) begin
							rd_word[CMF_B_TX_HALF] = lvl_le_half[i];
							rd_word[CMF_B_TX_EMPTY] = lvl_empty[i];
						end else begin
							rd_word[CMF_B_RX_OVFL] = rx_overflow_flag[i];
							rd_word[CMF_B_RX_FULL] = lvl_full[i];
							rd_word[CMF_B_RX_HALF] = lvl_ge_half[i];
							rd_word[CMF_B_RX_NEMPTY] = !lvl_empty[i];
						end
					end
					CMF_SEL_UPTR: begin
						rd_word[4:0] = queue_user_pointer[i];
					end
					default: begin
						rd_word = CMF_WORD_ZERO;
					end
				endcase
			end
		end
	end

	// Read data stands only in the cycle after the read strobe.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			reg_rdata <= CMF_WORD_ZERO;
		end else begin
			reg_rdata <= reg_rd ? rd_word : CMF_WORD_ZERO;
		end
	end

	cmf_tx_pick #(
		.NUM_FIFOS(NUM_FIFOS)
	) u_pick (
		.ready(pick_ready),
		.prio_flat(prio_flat),
		.found(pick_found),
		.winner(pick_winner)
	);

	// Transmit selection offered to the protocol engine.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			tx_go <= 1'b0;
			tx_fifo <= 5'h00;
		end else begin
			tx_go <= pick_found;
			tx_fifo <= pick_winner;
		end
	end

	// Storage format per FIFO; transmit FIFOs never see the payload option.
	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			payload_only_map <= CMF_WORD_ZERO;
		end else begin
			payload_only_map <= CMF_WORD_ZERO;
			payload_only_map[NUM_FIFOS-1:0] <= payload_only_store & ~direction_select;
		end
	end

endmodule : cmf_ctrl

// ==== dv/cmf_ctrl_properties.sv ====
`timescale 1ns/10ps
module cmf_ctrl_properties #(
	parameter int NUM_FIFOS = 32
) (
	// Clock and reset.
	input wire logic clk_sys,
	input wire logic rst,
	// Register port.
	input wire logic [cmf_pkg::CMF_ADDR_W-1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	// Mode and engine.
	input wire logic [2:0] operating_mode_field,
	input wire cmf_pkg::cmf_eng_ev_t eng_ev,
	input wire logic tx_go,
	input wire logic [4:0] tx_fifo,
	input wire logic [31:0] payload_only_map
);
	import cmf_pkg::*;
	default clocking main_cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	wire logic rd_ctrl = reg_rd && reg_addr[1:0] == CMF_SEL_CTRL;
	wire logic rd_int = reg_rd && reg_addr[1:0] == CMF_SEL_INT;
	wire logic quiet = !eng_ev.tx_arb_lost && !eng_ev.tx_error;

	rdata_idle_a: assert property (!reg_rd |=> reg_rdata == CMF_WORD_ZERO)
		else $error("read data not zero outside a read");
	ctrl_reserved_a: assert property (rd_ctrl |=> reg_rdata[31:21] == 11'h0
		&& !reg_rdata[15] && !reg_rdata[13] && reg_rdata[11:8] == 4'h0)
		else $error("reserved control bits not zero");
	flag_sides_a: assert property (rd_int |=> !(|reg_rdata[9:8] && |reg_rdata[3:0]))
		else $error("transmit and receive flags both set");
	level_order_a: assert property (rd_int |=> (!reg_rdata[2] || reg_rdata[1:0] == 2'h3)
		&& (!reg_rdata[8] || reg_rdata[9]) && reg_rdata[31:10] == 22'h0)
		else $error("level flags inconsistent");
	unmapped_zero_a: assert property (reg_rd && (reg_addr[6:2] >= NUM_FIFOS
		|| reg_addr[1:0] == 2'h3) |=> reg_rdata == CMF_WORD_ZERO)
		else $error("unmapped read not zero");
	status_clear_a: assert property ((rd_ctrl && quiet) ##1 quiet ##1
		(rd_ctrl && quiet && reg_addr == $past(reg_addr, 2)) |=> reg_rdata[5:4] == 2'h0)
		else $error("arbitration or error flag survived a read");
	reset_done_a: assert property ((reg_wr && reg_addr[1:0] == CMF_SEL_CTRL && reg_wdata[14])
		##3 (rd_ctrl && reg_addr == $past(reg_addr, 3)) |=> !reg_rdata[14])
		else $error("reset bit not cleared by hardware");
	pick_range_a: assert property (tx_go |-> tx_fifo < NUM_FIFOS)
		else $error("transmit pick out of range");
	tx_payload_a: assert property (rd_ctrl ##1 (reg_rdata[CMF_B_DIR] && !reg_wr)
		|-> !payload_only_map[$past(reg_addr[6:2])])
		else $error("payload option active on transmit FIFO");
	map_range_a: assert property ((payload_only_map >> NUM_FIFOS) == 0)
		else $error("payload map bit beyond last FIFO");
endmodule : cmf_ctrl_properties

// ==== dv/cmf_eng_model.sv ====
`timescale 1ns/10ps
module cmf_eng_model (
	// Clock.
	input wire logic clk_sys,
	// Pick from the controller.
	input wire logic tx_go,
	input wire logic [4:0] tx_fifo,
	// Events to the controller.
	output cmf_pkg::cmf_eng_ev_t eng_ev
);
	import cmf_pkg::*;
	int served;
	initial begin
		eng_ev = '0;
		served = 0;
	end
	// Kind bits: store, done, abort, arb lost, error, remote.
	task send(input logic [5:0] kind, input logic [4:0] idx);
		@(posedge clk_sys);
		eng_ev <= {kind, idx};
		@(posedge clk_sys);
		eng_ev <= '0;
	endtask : send
	// Sends up to n messages; gap of at least 3 lets the pick settle again.
	task serve(input int n, input int gap);
		int w;
		repeat (n) begin
			for (w = 0; w < 30 && tx_go !== 1'b1; w++) @(posedge clk_sys);
			if (tx_go === 1'b1) begin
				send(6'b010000, tx_fifo);
				served++;
			end
			repeat (gap) @(posedge clk_sys);
		end
	endtask : serve
endmodule : cmf_eng_model

// ==== dv/cmf_ctrl_tb.sv ====
`timescale 1ns/10ps
module cmf_ctrl_tb;
	import cmf_pkg::*;
	logic clk_sys, rst, reg_wr, reg_rd, tx_go;
	logic [6:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, map, d, e;
	logic [2:0] mode;
	logic [4:0] tx_fifo;
	cmf_eng_ev_t eng_ev;
	int mismatches, num_checks, k, cnt;

	cmf_ctrl #(.NUM_FIFOS(4)) dut_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.operating_mode_field(mode), .eng_ev(eng_ev), .tx_go(tx_go), .tx_fifo(tx_fifo),
		.payload_only_map(map));
	cmf_eng_model eng_u (.clk_sys(clk_sys), .tx_go(tx_go), .tx_fifo(tx_fifo), .eng_ev(eng_ev));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	task wrap_up;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : wrap_up
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task wr(input logic [4:0] i, input logic [1:0] s, input logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= {i, s};
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [4:0] i, input logic [1:0] s, output logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= {i, s};
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 v = reg_rdata;
	endtask : rd

	initial begin
		#100000;
		mismatches++;
		wrap_up();
	end

	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		mode = 3'h0;
		mismatches = 0;
		num_checks = 0;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		rd(0, CMF_SEL_CTRL, d);
		chk(d, 32'h0000_0000);
		rd(0, CMF_SEL_INT, d);
		chk(d, 32'h0000_0000);
		wr(1, CMF_SEL_CTRL, 32'h0003_1000);
		rd(1, CMF_SEL_CTRL, d);
		chk(d, 32'h0000_0000);
		@(posedge clk_sys) mode <= CMF_MODE_CONFIG;
		wr(1, CMF_SEL_CTRL, 32'h0003_1000);
		rd(1, CMF_SEL_CTRL, d);
		chk(d, 32'h0003_1000);
		chk(map, 32'h0000_0002);
		wr(1, CMF_SEL_CTRL, 32'h0003_1080);
		rd(1, CMF_SEL_CTRL, d);
		chk(map, 32'h0000_0000);
		chk(d, 32'h0003_1080);
		wr(3, CMF_SEL_CTRL, 32'hFFFF_8F00);
		rd(3, CMF_SEL_CTRL, d);
		chk(d, 32'h001F_0000);
		wr(0, CMF_SEL_CTRL, 32'h0001_0000);
		@(posedge clk_sys) mode <= 3'h0;
		// Transmit FIFO of depth four, pushed one past full.
		for (k = 0; k <= 5; k++) begin
			if (k > 0) wr(1, CMF_SEL_CTRL, 32'h0000_2080);
			cnt = (k > 4) ? 4 : k;
			e = '0;
			e[CMF_B_TX_HALF] = (cnt * 2 <= 4);
			e[CMF_B_TX_EMPTY] = (cnt == 0);
			rd(1, CMF_SEL_INT, d);
			chk(d, e);
			rd(1, CMF_SEL_UPTR, d);
			chk(d, 32'(cnt % 4));
		end
		wr(1, CMF_SEL_CTRL, 32'h0000_0089);
		for (k = 0; k < 20 && tx_go !== 1'b1; k++) @(posedge clk_sys);
		chk({31'h0, tx_go}, 32'h0000_0001);
		chk({27'h0, tx_fifo}, 32'h0000_0001);
		eng_u.send(6'b001110, 1);
		// The payload option stays stored on a transmit FIFO, it only has no effect.
		rd(1, CMF_SEL_CTRL, d);
		chk(d, 32'h0003_10F9);
		rd(1, CMF_SEL_CTRL, d);
		chk(d, 32'h0003_10C9);
		eng_u.serve(2, 3);
		eng_u.serve(3, 10);
		chk(32'(eng_u.served), 32'h0000_0004);
		chk({31'h0, tx_go}, 32'h0000_0000);
		rd(1, CMF_SEL_CTRL, d);
		chk(d, 32'h0003_1081);
		// Receive FIFO of depth two, one store past full.
		for (k = 1; k <= 3; k++) begin
			eng_u.send(6'b100000, 0);
			cnt = (k > 2) ? 2 : k;
			e = {28'h0, k > 2, cnt == 2, cnt * 2 >= 2, cnt > 0};
			rd(0, CMF_SEL_INT, d);
			chk(d, e);
		end
		wr(0, CMF_SEL_CTRL, 32'h0000_2000);
		rd(0, CMF_SEL_UPTR, d);
		chk(d, 32'h0000_0001);
		rd(0, CMF_SEL_INT, d);
		chk(d, 32'h0000_000B);
		wr(0, CMF_SEL_INT, 32'h0000_0000);
		rd(0, CMF_SEL_INT, d);
		chk(d, 32'h0000_0003);
		wr(0, CMF_SEL_CTRL, 32'h0000_4000);
		@(posedge clk_sys);
		d = 32'h0000_4000;
		for (k = 0; k < 10 && d[14] !== 1'b0; k++) rd(0, CMF_SEL_CTRL, d);
		chk(d, 32'h0001_0000);
		rd(0, CMF_SEL_INT, d);
		chk(d, 32'h0000_0000);
		rd(0, CMF_SEL_UPTR, d);
		chk(d, 32'h0000_0000);
		wr(2, CMF_SEL_CTRL, 32'h0000_0084);
		eng_u.send(6'b000001, 2);
		rd(2, CMF_SEL_CTRL, d);
		chk(d, 32'h0000_008C);
		// Higher priority on the higher index must win the pick.
		wr(1, CMF_SEL_CTRL, 32'h0000_2088);
		wr(2, CMF_SEL_CTRL, 32'h0000_208F);
		repeat (2) @(posedge clk_sys);
		chk({27'h0, tx_fifo}, 32'h0000_0002);
		eng_u.serve(1, 3);
		chk({27'h0, tx_fifo}, 32'h0000_0001);
		eng_u.serve(1, 3);
		chk({31'h0, tx_go}, 32'h0000_0000);
		chk(32'(eng_u.served), 32'h0000_0006);
		rd(5, CMF_SEL_CTRL, d);
		chk(d, 32'h0000_0000);
		rd(1, 2'h3, d);
		chk(d, 32'h0000_0000);
		wrap_up();
	end
endmodule : cmf_ctrl_tb

bind cmf_ctrl cmf_ctrl_properties #(.NUM_FIFOS(NUM_FIFOS)) props_u (.clk_sys(clk_sys),
	.rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .operating_mode_field(operating_mode_field), .eng_ev(eng_ev),
	.tx_go(tx_go), .tx_fifo(tx_fifo), .payload_only_map(payload_only_map));
